/* File: common/mobf_map.svh */
// offsets, character codes and timing constants of the output buffer formatter
`ifndef MOBF_MAP_SVH
`define MOBF_MAP_SVH

`define MOBF_MSG_LEN      21
`define MOBF_POS_SIGN     2
`define MOBF_POS_MANT     3
`define MOBF_POS_EXPI     15
`define MOBF_POS_EXPS     16
`define MOBF_POS_EXPH     17
`define MOBF_POS_EXPL     18
`define MOBF_POS_CR       19
`define MOBF_POS_LF       20

`define MOBF_CH_CR        8'h0d
`define MOBF_CH_LF        8'h0a
`define MOBF_CH_SP        8'h20
`define MOBF_CH_PLUS      8'h2b
`define MOBF_CH_MINUS     8'h2d
`define MOBF_CH_POINT     8'h2e
`define MOBF_CH_EXP       8'h45
`define MOBF_CH_ZERO      8'h30
`define MOBF_CH_TERM      8'h0a

`define MOBF_CLK_MHZ      40
`define MOBF_GATE_BASE_US 100
`define MOBF_RES_MAX      5
`define MOBF_CMD_DEPTH    32

`endif

/* File: common/mobf_pkg.sv */
// types shared by the output buffer formatter
package mobf_pkg;

   // measurement letters first, recall letters after
   typedef enum logic [3:0] {
      MOBF_FA, MOBF_PA, MOBF_TI, MOBF_TA, MOBF_PH, MOBF_RA, MOBF_CK, MOBF_TM, MOBF_TC,
      MOBF_UT, MOBF_RS, MOBF_NL, MOBF_DT, MOBF_SF, MOBF_MS, MOBF_GS
   } mobf_code_t;

   // mant: 11 bcd digits, msd first; dp: digits before the point (0..11)
   // exp3: exponent divided by three
   typedef struct packed {
      mobf_code_t  code;
      logic        neg;
      logic [43:0] mant;
      logic [3:0]  dp;
      logic        exp_neg;
      logic [4:0]  exp3;
   } mobf_value_t;

   typedef enum logic {MOBF_TX_IDLE, MOBF_TX_SEND} mobf_tx_st_t;
   typedef enum logic {MOBF_CMD_COLLECT, MOBF_CMD_EXEC} mobf_cmd_st_t;
   typedef enum logic [1:0] {MOBF_G_IDLE, MOBF_G_OPEN, MOBF_G_WAIT} mobf_gate_st_t;

endpackage

/* File: hw/mobf_cmd_mem.sv */
// command string memory with registered read data
`timescale 1ns/10ps
module mobf_cmd_mem #(
   parameter int W     = 8,
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // clock
   input  wire logic          clk,
   input  wire logic          ce,
   // write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   // read port
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);
   logic [W-1:0] mem [DEPTH];

   // no reset: contents are only read after being written
   always_ff @(posedge clk) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         if (rd_en) begin
            rd_data <= mem[rd_addr];
         end
      end
   end
endmodule

/* File: hw/mobf_formatter.sv */
// measurement output buffer, message formatter and command collector
`timescale 1ns/10ps
`include "mobf_map.svh"
module mobf_formatter #(
   parameter int GATE_BASE_CYC = `MOBF_GATE_BASE_US * `MOBF_CLK_MHZ,
   parameter int CMD_DEPTH     = `MOBF_CMD_DEPTH
) (
   // clock and reset
   input  wire logic                 CLK,
   input  wire logic                 RST,
   input  wire logic                 CE,
   // mode
   input  wire logic                 TALK_ONLY,
   input  wire logic                 TALK_ADDR,
   input  wire logic                 LISTEN_ADDR,
   input  wire logic                 SPECIAL81,
   // measurement engine
   input  wire logic [2:0]           RESOLUTION,
   input  wire logic                 HOLD,
   input  wire logic                 RESET_KEY,
   input  wire logic                 MEAS_DONE,
   input  wire mobf_pkg::mobf_value_t MEAS_VALUE,
   input  wire logic                 RECALL_LOAD,
   input  wire mobf_pkg::mobf_value_t RECALL_VALUE,
   output logic                      GATE_OPEN,
   output logic                      BUF_FULL,
   // talker byte stream
   input  wire logic                 XFER_REQ,
   input  wire logic                 TX_READY,
   output logic [7:0]                TX_DATA,
   output logic                      TX_VALID,
   output logic                      TX_LAST,
   // listener byte stream
   input  wire logic [7:0]           RX_DATA,
   input  wire logic                 RX_VALID,
   input  wire logic                 RX_IMM,
   input  wire logic                 RX_END,
   output logic                      RX_READY,
   // commands to execute
   output logic [7:0]                CMD_DATA,
   output logic                      CMD_VALID,
   output logic                      CMD_LAST,
   output logic                      CMD_OVF
);
   import mobf_pkg::*;

   localparam int AW = $clog2(CMD_DEPTH);

   generate
      if (CMD_DEPTH < 2 || (1 << AW) != CMD_DEPTH || GATE_BASE_CYC < 1) begin : g_chk
         $error("mobf_formatter: CMD_DEPTH must be a power of two, GATE_BASE_CYC >= 1");
      end
   endgenerate

   function automatic logic [15:0] letters(input mobf_code_t c);
      case (c)
         // measurement codes
         MOBF_FA: letters = "FA";
         MOBF_PA: letters = "PA";
         MOBF_TI: letters = "TI";
         MOBF_TA: letters = "TA";
         MOBF_PH: letters = "PH";
         MOBF_RA: letters = "RA";
         MOBF_CK: letters = "CK";
         MOBF_TM: letters = "TM";
         MOBF_TC: letters = "TC";
         // recall codes
         MOBF_UT: letters = "UT";
         MOBF_RS: letters = "RS";
         MOBF_NL: letters = "NL";
         MOBF_DT: letters = "DT";
         MOBF_SF: letters = "SF";
         MOBF_MS: letters = "MS";
         MOBF_GS: letters = "GS";
         default: letters = "FA";
      endcase
   endfunction

   function automatic logic [7:0] msg_byte(input mobf_value_t v, input logic [4:0] i,
                                           input logic sp);
      logic [15:0] lt;
      logic [3:0]  k;
      logic [3:0]  di;
      logic [6:0]  e;
      logic [3:0]  dig;
      lt  = letters(v.code);
      k   = 4'(i - 5'(`MOBF_POS_MANT));
      di  = (k < v.dp) ? k : 4'(k - 4'h1);
      e   = {2'h0, v.exp3} + {1'h0, v.exp3, 1'h0};
      dig = v.mant[4*(10 - int'(di)) +: 4];
      if (i == 5'h00) begin
         msg_byte = sp ? `MOBF_CH_SP : lt[15:8];
      end else if (i == 5'h01) begin
         msg_byte = sp ? `MOBF_CH_SP : lt[7:0];
      end else if (i == 5'(`MOBF_POS_SIGN)) begin
         msg_byte = v.neg ? `MOBF_CH_MINUS : `MOBF_CH_PLUS;
      end else if (i < 5'(`MOBF_POS_EXPI)) begin
         msg_byte = (k == v.dp) ? `MOBF_CH_POINT : (`MOBF_CH_ZERO | {4'h0, dig});
      end else if (i == 5'(`MOBF_POS_EXPI)) begin
         msg_byte = `MOBF_CH_EXP;
      end else if (i == 5'(`MOBF_POS_EXPS)) begin
         msg_byte = v.exp_neg ? `MOBF_CH_MINUS : `MOBF_CH_PLUS;
      end else if (i == 5'(`MOBF_POS_EXPH)) begin
         msg_byte = `MOBF_CH_ZERO | {1'h0, 7'(e / 7'd10)};
      end else if (i == 5'(`MOBF_POS_EXPL)) begin
         msg_byte = `MOBF_CH_ZERO | {1'h0, 7'(e % 7'd10)};
      end else if (i == 5'(`MOBF_POS_CR)) begin
         msg_byte = `MOBF_CH_CR;
      end else begin
         msg_byte = `MOBF_CH_LF;
      end
   endfunction

   function automatic logic [31:0] gate_len(input logic [2:0] r);
      logic [31:0] g;
      g = 32'(GATE_BASE_CYC);
      for (int j = 0; j < `MOBF_RES_MAX; j++) begin
         if (j < int'(r)) begin
            g = 32'(g * 32'd10);
         end
      end
      gate_len = g;
   endfunction

   // ---------------- gate timing ----------------
   mobf_gate_st_t gst_q, gst_d;
   logic [31:0]   gcnt_q, gcnt_d;
   logic          arm_q, arm_d;
   logic          gate_q, gate_d;

   always_comb begin
      gst_d  = gst_q;
      gcnt_d = gcnt_q;
      // key press remembered until a cycle starts
      arm_d  = arm_q | RESET_KEY;
      case (gst_q)
         MOBF_G_IDLE: begin
            if (!HOLD || arm_q) begin
               gst_d  = MOBF_G_OPEN;
               arm_d  = RESET_KEY;
               gcnt_d = gate_len(RESOLUTION > 3'(`MOBF_RES_MAX) ?
                                 3'(`MOBF_RES_MAX) : RESOLUTION);
            end
         end
         MOBF_G_OPEN: begin
            gcnt_d = gcnt_q - 32'h1;
            if (gcnt_q <= 32'h1) begin
               gst_d = MOBF_G_WAIT;
            end
         end
         MOBF_G_WAIT: begin
            if (MEAS_DONE) begin
               gst_d = MOBF_G_IDLE;
            end
         end
         default: gst_d = MOBF_G_IDLE;
      endcase
      gate_d = (gst_d == MOBF_G_OPEN);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         gst_q  <= MOBF_G_IDLE;
         gcnt_q <= 32'h0;
         arm_q  <= 1'b0;
         gate_q <= 1'b0;
      end else if (CE) begin
         gst_q  <= gst_d;
         gcnt_q <= gcnt_d;
         arm_q  <= arm_d;
         gate_q <= gate_d;
      end
   end

   // ---------------- output buffer and talker ----------------
   mobf_tx_st_t tst_q, tst_d;
   mobf_value_t msg_q, msg_d, pend_val_q, pend_val_d;
   logic        valid_q, valid_d, pend_q, pend_d;
   logic        treq_q, treq_d;
   logic [4:0]  idx_q, idx_d;
   logic [7:0]  txd_q, txd_d;
   logic        txv_q, txv_d, txl_q, txl_d;
   logic        talk_ok, busy, done, abort, new_in;
   mobf_value_t new_val;

   always_comb begin
      new_in  = MEAS_DONE | RECALL_LOAD;
      new_val = MEAS_DONE ? MEAS_VALUE : RECALL_VALUE;
      talk_ok = TALK_ONLY ? treq_q : TALK_ADDR;
      busy    = (tst_q == MOBF_TX_SEND);
      done    = busy && TX_READY && (idx_q == 5'(`MOBF_MSG_LEN - 1));
      abort   = busy && !TALK_ONLY && !TALK_ADDR && !done;
      tst_d   = tst_q;
      idx_d   = idx_q;
      txd_d   = txd_q;
      txv_d   = txv_q;
      txl_d   = txl_q;
      treq_d  = treq_q;
      case (tst_q)
         MOBF_TX_IDLE: begin
            if (talk_ok && valid_q) begin
               tst_d  = MOBF_TX_SEND;
               idx_d  = 5'h0;
               // a load in the start cycle is what gets sent
               txd_d  = msg_byte(new_in ? new_val : msg_q, 5'h0, SPECIAL81);
               txv_d  = 1'b1;
               txl_d  = 1'b0;
               treq_d = 1'b0;
            end
         end
         MOBF_TX_SEND: begin
            if (!TALK_ONLY && !TALK_ADDR) begin
               // unaddressed mid-message: drop it, buffer kept
               tst_d = MOBF_TX_IDLE;
               txv_d = 1'b0;
               txl_d = 1'b0;
            end else if (done) begin
               tst_d = MOBF_TX_IDLE;
               txv_d = 1'b0;
               txl_d = 1'b0;
            end else if (TX_READY) begin
               idx_d = idx_q + 5'h1;
               txd_d = msg_byte(msg_q, idx_d, SPECIAL81);
               txl_d = (idx_d == 5'(`MOBF_MSG_LEN - 1));
            end
         end
         default: tst_d = MOBF_TX_IDLE;
      endcase
      // a trigger in the start cycle survives
      if (TALK_ONLY && XFER_REQ) begin
         treq_d = 1'b1;
      end
      if (!TALK_ONLY) begin
         treq_d = 1'b0;
      end

      msg_d      = msg_q;
      valid_d    = valid_q;
      pend_d     = pend_q;
      pend_val_d = pend_val_q;
      if (new_in && busy && !done && !abort) begin
         // park newest result behind the transfer
         pend_d     = 1'b1;
         pend_val_d = new_val;
      end else if (new_in) begin
         msg_d   = new_val;
         valid_d = 1'b1;
         pend_d  = 1'b0;
      end else if (done) begin
         // empty unless an update was parked
         valid_d = pend_q;
         pend_d  = 1'b0;
         if (pend_q) begin
            msg_d = pend_val_q;
         end
      end else if (abort) begin
         msg_d  = pend_q ? pend_val_q : msg_q;
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tst_q      <= MOBF_TX_IDLE;
         msg_q      <= '0;
         pend_val_q <= '0;
         valid_q    <= 1'b0;
         pend_q     <= 1'b0;
         treq_q     <= 1'b0;
         idx_q      <= 5'h0;
         txd_q      <= 8'h00;
         txv_q      <= 1'b0;
         txl_q      <= 1'b0;
      end else if (CE) begin
         tst_q      <= tst_d;
         msg_q      <= msg_d;
         pend_val_q <= pend_val_d;
         valid_q    <= valid_d;
         pend_q     <= pend_d;
         treq_q     <= treq_d;
         idx_q      <= idx_d;
         txd_q      <= txd_d;
         txv_q      <= txv_d;
         txl_q      <= txl_d;
      end
   end

   // ---------------- command collector ----------------
   mobf_cmd_st_t cst_q, cst_d;
   logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
   logic         rxr_q, rxr_d, ovf_q, ovf_d, cv_q, cv_d, cl_q, cl_d;
   logic         acc, term, wr_en, rd_en;

   always_comb begin
      cst_d = cst_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      ovf_d = ovf_q;
      acc   = RX_VALID && rxr_q;
      term  = acc && (RX_DATA == `MOBF_CH_TERM);
      wr_en = 1'b0;
      rd_en = 1'b0;
      case (cst_q)
         MOBF_CMD_COLLECT: begin
            if (acc && !term) begin
               if (wr_q < (AW+1)'(CMD_DEPTH)) begin
                  wr_en = 1'b1;
                  wr_d  = wr_q + 1'b1;
               end else begin
                  ovf_d = 1'b1;
               end
            end
            if (term || (acc && RX_IMM) || (rxr_q && RX_END)) begin
               cst_d = MOBF_CMD_EXEC;
               rd_d  = '0;
            end
         end
         MOBF_CMD_EXEC: begin
            if (rd_q < wr_q) begin
               rd_en = 1'b1;
               rd_d  = rd_q + 1'b1;
            end else begin
               cst_d = MOBF_CMD_COLLECT;
               wr_d  = '0;
               ovf_d = 1'b0;
            end
         end
         default: cst_d = MOBF_CMD_COLLECT;
      endcase
      cv_d  = rd_en;
      cl_d  = rd_en && (rd_d == wr_q);
      // bytes taken only as addressed listener
      rxr_d = (cst_d == MOBF_CMD_COLLECT) && LISTEN_ADDR && !TALK_ONLY;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cst_q <= MOBF_CMD_COLLECT;
         wr_q  <= '0;
         rd_q  <= '0;
         rxr_q <= 1'b0;
         ovf_q <= 1'b0;
         cv_q  <= 1'b0;
         cl_q  <= 1'b0;
      end else if (CE) begin
         cst_q <= cst_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         rxr_q <= rxr_d;
         ovf_q <= ovf_d;
         cv_q  <= cv_d;
         cl_q  <= cl_d;
      end
   end

   mobf_cmd_mem #(
      .W     (8),
      .DEPTH (CMD_DEPTH),
      .AW    (AW)
   ) u_mem (
      .clk     (CLK),
      .ce      (CE),
      .wr_en   (wr_en),
      .wr_addr (wr_q[AW-1:0]),
      .wr_data (RX_DATA),
      .rd_en   (rd_en),
      .rd_addr (rd_q[AW-1:0]),
      .rd_data (CMD_DATA)
   );

   assign GATE_OPEN = gate_q;
   assign BUF_FULL  = valid_q;
   assign TX_DATA   = txd_q;
   assign TX_VALID  = txv_q;
   assign TX_LAST   = txl_q;
   assign RX_READY  = rxr_q;
   assign CMD_VALID = cv_q;
   assign CMD_LAST  = cl_q;
   assign CMD_OVF   = ovf_q;
endmodule

/* File: bench/mobf_formatter_asserts.sv */
// concurrent checks on the formatter top ports
`timescale 1ns/10ps
module mobf_formatter_chk #(
   parameter int GATE_BASE_CYC = 4
) (
   // clock and reset
   input wire logic       CLK,
   input wire logic       RST,
   // mode and engine
   input wire logic       TALK_ONLY,
   input wire logic       LISTEN_ADDR,
   input wire logic       SPECIAL81,
   input wire logic [2:0] RESOLUTION,
   input wire logic       HOLD,
   input wire logic       RESET_KEY,
   input wire logic       MEAS_DONE,
   input wire logic       RECALL_LOAD,
   input wire logic       GATE_OPEN,
   input wire logic       BUF_FULL,
   // streams
   input wire logic       TX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic       TX_VALID,
   input wire logic       TX_LAST,
   input wire logic       RX_READY,
   input wire logic       CMD_VALID
);
   logic [4:0] nb_q, nb_d;
   logic       pend_q, pend_d, arm_q, arm_d, gp_q;
   int         open_q, open_d, len_q, len_d;
   logic       take, fin;

   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   assign take = TX_VALID & TX_READY;
   assign fin  = take & TX_LAST;

   // byte index, parked-load flag, armed key, gate length
   always_comb begin
      nb_d   = !TX_VALID ? 5'h00 : take ? nb_q + 5'h01 : nb_q;
      pend_d = TX_VALID & (pend_q | MEAS_DONE | RECALL_LOAD);
      arm_d  = RESET_KEY | (arm_q & !(GATE_OPEN & !gp_q));
      open_d = GATE_OPEN ? open_q + 1 : 0;
      len_d  = len_q;
      if (GATE_OPEN & !gp_q)
         len_d = GATE_BASE_CYC * (10 ** ((RESOLUTION > 3'h5) ? 5 : RESOLUTION));
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         nb_q   <= 5'h00;
         pend_q <= 1'b0;
         arm_q  <= 1'b0;
         gp_q   <= 1'b0;
         open_q <= 0;
         len_q  <= 0;
      end else begin
         nb_q   <= nb_d;
         pend_q <= pend_d;
         arm_q  <= arm_d;
         gp_q   <= GATE_OPEN;
         open_q <= open_d;
         len_q  <= len_d;
      end
   end

   a_byte_count: assert property (
      TX_VALID && TX_LAST |-> nb_q == 5'h14)
      else $error("last flag not on byte 21");
   a_line_end: assert property (
      TX_VALID && nb_q >= 5'h13 |-> TX_DATA == (TX_LAST ? 8'h0a : 8'h0d))
      else $error("message tail is not CR LF");
   a_sign_byte: assert property (
      TX_VALID && nb_q == 5'h02 |-> TX_DATA inside {8'h2b, 8'h2d})
      else $error("byte 3 is not a sign");
   a_exp_letter: assert property (
      TX_VALID && nb_q == 5'h0f |-> TX_DATA == 8'h45)
      else $error("byte 16 is not the exponent letter");
   a_space_letters: assert property (
      TX_VALID && nb_q < 5'h02 && SPECIAL81 |-> TX_DATA == 8'h20)
      else $error("letters not replaced by spaces");
   a_start_full: assert property (
      $rose(TX_VALID) |-> $past(BUF_FULL))
      else $error("transfer started from an empty buffer");
   a_buf_empty: assert property (
      fin && !pend_q && !MEAS_DONE && !RECALL_LOAD |=> !BUF_FULL && !TX_VALID)
      else $error("buffer not empty after transfer");
   a_load_full: assert property (
      (MEAS_DONE || RECALL_LOAD) && !TX_VALID |=> BUF_FULL)
      else $error("load did not fill buffer");
   a_park_load: assert property (
      fin && pend_q |=> BUF_FULL)
      else $error("parked result not loaded after transfer");
   a_gate_len: assert property (
      $fell(GATE_OPEN) |-> open_q == len_q)
      else $error("gate length does not follow resolution");
   a_hold_key: assert property (
      $rose(GATE_OPEN) |-> !$past(HOLD) || arm_q)
      else $error("gate opened in hold without key");
   a_listen_only: assert property (
      RX_READY |-> $past(LISTEN_ADDR) && !$past(TALK_ONLY))
      else $error("commands accepted while not listener");
   a_cmd_collect: assert property (
      $rose(CMD_VALID) |-> !RX_READY)
      else $error("replay while still collecting");
endmodule

bind mobf_formatter mobf_formatter_chk #(.GATE_BASE_CYC(GATE_BASE_CYC)) u_chk (
   .CLK(CLK), .RST(RST), .TALK_ONLY(TALK_ONLY), .LISTEN_ADDR(LISTEN_ADDR),
   .SPECIAL81(SPECIAL81), .RESOLUTION(RESOLUTION), .HOLD(HOLD), .RESET_KEY(RESET_KEY),
   .MEAS_DONE(MEAS_DONE), .RECALL_LOAD(RECALL_LOAD), .GATE_OPEN(GATE_OPEN),
   .BUF_FULL(BUF_FULL), .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
   .TX_LAST(TX_LAST), .RX_READY(RX_READY), .CMD_VALID(CMD_VALID));

/* File: bench/mobf_listener.sv */
// behavioural bus listener taking talker bytes
`timescale 1ns/10ps
module mobf_listener (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // 1 inserts random stalls
   input  wire logic         slow,
   // talker stream
   input  wire logic [7:0]   tx_data,
   input  wire logic         tx_valid,
   input  wire logic         tx_last,
   output logic              tx_ready,
   // assembled message, byte 1 on top
   output logic [167:0]      msg,
   output logic              msg_ok
);
   integer seed = 98;
   integer r;

   initial tx_ready <= 1'b0;

   always @(negedge clk) begin
      r = $random(seed);
      tx_ready <= !slow || r[1:0] != 2'h0;
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         msg    <= '0;
         msg_ok <= 1'b0;
      end else begin
         msg_ok <= tx_valid & tx_ready & tx_last;
         if (tx_valid & tx_ready)
            msg <= {msg[159:0], tx_data};
      end
   end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the output buffer formatter
`timescale 1ns/10ps
module tb_top;
   import mobf_pkg::*;
   logic         CLK = 1'b0, RST = 1'b1, CE = 1'b1, TALK_ONLY = 1'b1, TALK_ADDR = 1'b0;
   // listener flag up in talk-only, where it must be ignored
   logic         LISTEN_ADDR = 1'b1, SPECIAL81 = 1'b0, HOLD = 1'b0, RESET_KEY = 1'b0;
   logic         MEAS_DONE = 1'b0, RECALL_LOAD = 1'b0, XFER_REQ = 1'b0, TX_READY;
   logic         RX_VALID = 1'b0, RX_IMM = 1'b0, RX_END = 1'b0, slow = 1'b0, gp = 1'b0;
   logic [2:0]   RESOLUTION = 3'h0;
   logic [7:0]   RX_DATA = 8'h00, TX_DATA, CMD_DATA;
   mobf_value_t  MEAS_VALUE = '0, RECALL_VALUE = '0, v;
   logic         GATE_OPEN, BUF_FULL, TX_VALID, TX_LAST, RX_READY;
   logic         CMD_VALID, CMD_LAST, CMD_OVF, msg_ok;
   logic [167:0] msg, mq[$];
   logic [8:0]   cq[$];
   int           errors = 0, checks_done = 0, cycles = 0, rises = 0, r0, seed = 98;
   // small command memory so a short string overflows
   localparam int CD = 4;

   mobf_formatter #(.GATE_BASE_CYC(4), .CMD_DEPTH(CD)) uut (
      .CLK(CLK), .RST(RST), .CE(CE), .TALK_ONLY(TALK_ONLY), .TALK_ADDR(TALK_ADDR),
      .LISTEN_ADDR(LISTEN_ADDR), .SPECIAL81(SPECIAL81), .RESOLUTION(RESOLUTION), .HOLD(HOLD),
      .RESET_KEY(RESET_KEY), .MEAS_DONE(MEAS_DONE), .MEAS_VALUE(MEAS_VALUE),
      .RECALL_LOAD(RECALL_LOAD), .RECALL_VALUE(RECALL_VALUE), .GATE_OPEN(GATE_OPEN),
      .BUF_FULL(BUF_FULL), .XFER_REQ(XFER_REQ), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
      .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
      .RX_IMM(RX_IMM), .RX_END(RX_END), .RX_READY(RX_READY), .CMD_DATA(CMD_DATA),
      .CMD_VALID(CMD_VALID), .CMD_LAST(CMD_LAST), .CMD_OVF(CMD_OVF));

   mobf_listener u_lis (.clk(CLK), .rst(RST), .slow(slow), .tx_data(TX_DATA),
      .tx_valid(TX_VALID), .tx_last(TX_LAST), .tx_ready(TX_READY), .msg(msg), .msg_ok(msg_ok));

   initial forever #12.5 CLK = ~CLK;

   task automatic check(input logic [167:0] got, input logic [167:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic mobf_value_t rnd(input int c);
      mobf_value_t x;
      int r;
      r = $random(seed);
      x.code = mobf_code_t'(c[3:0]);
      x.neg = r[0];
      x.exp3 = r[5:1];
      x.exp_neg = r[6] && r[5:1] != 5'h00;
      x.dp = 4'({$random(seed)} % 12);
      for (int i = 0; i < 11; i++)
         x.mant[4*i +: 4] = 4'({$random(seed)} % 10);
      return x;
   endfunction

   // byte 1 lands in the top byte, as the listener assembles it
   function automatic logic [167:0] fmt(input mobf_value_t x, input logic sp);
      string        lt = "FAPATITAPHRACKTMTCUTRSNLDTSFMSGS";
      logic [167:0] m;
      int           k, e;
      k = 0;
      e = 3 * x.exp3;
      m = sp ? 168'h2020 : {lt[2 * x.code], lt[2 * x.code + 1]};
      m = {m[159:0], x.neg ? 8'h2d : 8'h2b};
      for (int i = 0; i < 12; i++) begin
         if (i == x.dp) begin
            m = {m[159:0], 8'h2e};
         end else begin
            m = {m[159:0], 8'h30 + {4'h0, x.mant[43 - 4 * k -: 4]}};
            k++;
         end
      end
      m = {m[119:0], 8'h45, x.exp_neg ? 8'h2d : 8'h2b, 8'(8'h30 + e / 10),
           8'(8'h30 + e % 10), 8'h0d, 8'h0a};
      return m;
   endfunction

   task automatic load(input mobf_value_t x, input logic rec);
      @(negedge CLK);
      MEAS_VALUE = x;
      RECALL_VALUE = x;
      MEAS_DONE = !rec;
      RECALL_LOAD = rec;
      @(negedge CLK);
      MEAS_DONE = 1'b0;
      RECALL_LOAD = 1'b0;
   endtask

   task automatic note_load(input int c, input logic rec);
      v = rnd(c);
      mq.push_back(fmt(v, SPECIAL81));
      load(v, rec);
   endtask

   task automatic trig;
      @(negedge CLK);
      XFER_REQ = 1'b1;
      @(negedge CLK);
      XFER_REQ = 1'b0;
   endtask

   task automatic wait_q(input int n);
      for (int k = 0; k < 3000 && mq.size() > n; k++)
         @(posedge CLK);
      @(negedge CLK);
   endtask

   task automatic rx(input logic [7:0] b, input logic imm, input logic fin, input logic vld);
      int k;
      @(negedge CLK);
      RX_DATA = b;
      RX_VALID = vld;
      RX_IMM = imm;
      RX_END = fin;
      k = 0;
      do begin
         @(posedge CLK);
         k++;
      end while (RX_READY !== 1'b1 && k < 200);
   endtask

   // mode 0 terminator char, 1 immediate last byte, 2 end message
   task automatic send_cmd(input string s, input int mode);
      for (int i = 0; i < s.len(); i++) begin
         if (i < CD)
            cq.push_back({i == s.len() - 1 || i == CD - 1, s[i]});
         rx(s[i], mode == 1 && i == s.len() - 1, 1'b0, 1'b1);
      end
      if (mode == 0)
         rx(8'h0a, 1'b0, 1'b0, 1'b1);
      if (mode == 2)
         rx(8'h00, 1'b0, 1'b1, 1'b0);
      @(negedge CLK);
      check(CMD_OVF, s.len() > CD);
      RX_VALID = 1'b0;
      RX_IMM = 1'b0;
      RX_END = 1'b0;
      for (int k = 0; k < 200 && cq.size() > 0; k++)
         @(negedge CLK);
   endtask

   always @(posedge CLK) begin
      cycles++;
      if (GATE_OPEN === 1'b1 && gp === 1'b0)
         rises++;
      gp = GATE_OPEN;
      if (msg_ok === 1'b1)
         check(msg, (mq.size() > 0) ? mq.pop_front() : '1);
      if (CMD_VALID === 1'b1)
         check({CMD_LAST, CMD_DATA}, (cq.size() > 0) ? cq.pop_front() : '1);
      if (cycles == 20000) begin
         errors++;
         test_done;
      end
   end

   initial begin
      repeat (16) @(posedge CLK);
      @(negedge CLK);
      RST = 1'b0;
      for (int i = 0; i < 16; i++) begin
         slow = i[0];
         SPECIAL81 = (i % 5 == 3);
         note_load(i, i > 8);
         trig;
         wait_q(0);
      end
      SPECIAL81 = 1'b0;
      $display("test letters done");
      load(rnd(1), 1'b0);
      note_load(2, 1'b0);
      trig;
      wait_q(0);
      check(BUF_FULL, 1'b0);
      $display("test overwrite done");
      check(RX_READY, 1'b0);
      slow = 1'b1;
      note_load(3, 1'b0);
      trig;
      for (int k = 0; k < 100 && TX_VALID !== 1'b1; k++)
         @(posedge CLK);
      note_load(4, 1'b0);
      wait_q(1);
      trig;
      wait_q(0);
      trig;
      repeat (30) @(negedge CLK);
      check(TX_VALID, 1'b0);
      note_load(5, 1'b0);
      wait_q(0);
      $display("test arbitration done");
      TALK_ONLY = 1'b0;
      LISTEN_ADDR = 1'b0;
      note_load(6, 1'b1);
      trig;
      repeat (40) @(negedge CLK);
      check(TX_VALID, 1'b0);
      TALK_ADDR = 1'b1;
      wait_q(0);
      repeat (20) @(negedge CLK);
      note_load(7, 1'b0);
      wait_q(0);
      TALK_ADDR = 1'b0;
      check(RX_READY, 1'b0);
      $display("test addressed done");
      LISTEN_ADDR = 1'b1;
      @(negedge CLK);
      check(RX_READY, 1'b1);
      send_cmd("FA", 0);
      send_cmd("FAS5", 1);
      send_cmd("TI", 2);
      send_cmd("FAS5T", 0);
      LISTEN_ADDR = 1'b0;
      $display("test commands done");
      HOLD = 1'b1;
      repeat (30) @(negedge CLK);
      load(rnd(8), 1'b0);
      repeat (30) @(negedge CLK);
      RESOLUTION = 3'h1;
      r0 = rises;
      repeat (60) @(negedge CLK);
      check(168'(rises - r0), 168'h0);
      RESET_KEY = 1'b1;
      @(negedge CLK);
      RESET_KEY = 1'b0;
      repeat (80) @(negedge CLK);
      load(rnd(9), 1'b0);
      repeat (60) @(negedge CLK);
      check(168'(rises - r0), 168'h1);
      $display("test hold done");
      check(168'(mq.size() + cq.size()), 168'h0);
      test_done;
   end
endmodule
